// file: verilog/lic_pkg.sv
// Package of constants and types for the logic input conditioning block
package lic_pkg;
   // ==========================================================
   // Sizes
   localparam int LIC_N_LOGIC = 20;
   localparam int LIC_N_CONTACT = 14;
   localparam int LIC_N_VIRT_ONLY = LIC_N_LOGIC - LIC_N_CONTACT;
   localparam int LIC_WORD_W = 16;
   localparam int LIC_SEL_W = 5;
   // ==========================================================
   // Virtual input word address range
   localparam logic [15:0] LIC_VIRT_ADDR_FIRST = 16'h0090;
   localparam logic [15:0] LIC_VIRT_ADDR_LAST = 16'h00a4;
   localparam logic [LIC_WORD_W-1:0] LIC_WORD_OFF = 16'h0000;
   localparam logic [LIC_WORD_W-1:0] LIC_WORD_RESET = 16'h0000;
   // ==========================================================
   // Timing
   localparam longint LIC_CLK_HZ = 20000000;
   localparam longint LIC_FREQ_50_HZ = 50;
   localparam longint LIC_FREQ_60_HZ = 60;
   // One power-frequency cycle, rounded up
   localparam int LIC_DEB_50_CYC =
      int'((LIC_CLK_HZ + LIC_FREQ_50_HZ - 1) / LIC_FREQ_50_HZ);
   localparam int LIC_DEB_60_CYC =
      int'((LIC_CLK_HZ + LIC_FREQ_60_HZ - 1) / LIC_FREQ_60_HZ);
   localparam int LIC_DEB_W = 20;
   localparam int LIC_DWELL_MIN_MS = 50;
   localparam int LIC_DWELL_MAX_MS = 200;
   // ==========================================================
   // Combination selection codes
   typedef enum logic [LIC_SEL_W-1:0] {
      LIC_SEL_DISABLED,
      LIC_SEL_C_CLOSED,
      LIC_SEL_C_OPEN,
      LIC_SEL_V_ON,
      LIC_SEL_V_OFF,
      LIC_SEL_CLOSED_AND_VON,
      LIC_SEL_CLOSED_AND_VOFF,
      LIC_SEL_OPEN_AND_VON,
      LIC_SEL_OPEN_AND_VOFF,
      LIC_SEL_CLOSED_OR_VON,
      LIC_SEL_CLOSED_OR_VOFF,
      LIC_SEL_OPEN_OR_VON,
      LIC_SEL_OPEN_OR_VOFF,
      LIC_SEL_CLOSED_XOR_VON,
      LIC_SEL_CLOSED_XOR_VOFF,
      LIC_SEL_OPEN_XOR_VON,
      LIC_SEL_OPEN_XOR_VOFF
   } lic_sel_t;
endpackage : lic_pkg

// file: verilog/lic_debounce.sv
// Debounce stage for one contact input
`timescale 1ns/1ps
`default_nettype none
module lic_debounce
   import lic_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic rst_b, // Async reset, active low
   input wire logic raw, // Raw contact level, 1 = closed
   input wire logic [LIC_DEB_W-1:0] period_cyc, // Cycles in one power cycle
   output logic state // Accepted level, 1 = closed
);
   logic last_r, last_nxt;
   logic state_r, state_nxt;
   logic [LIC_DEB_W-1:0] cnt_r, cnt_nxt;

   // ==========================================================
   // Stability counter
   always_comb begin
      last_nxt = raw;
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      if (raw != last_r) begin
         cnt_nxt = '0;
      end else if (raw != state_r) begin
         if (cnt_r >= period_cyc - 20'h00001) begin
            state_nxt = raw;
            cnt_nxt = '0;
         end else begin
            cnt_nxt = cnt_r + 20'h00001;
         end
      end else begin
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         last_r <= 1'b0;
         state_r <= 1'b0;
         cnt_r <= '0;
      end else begin
         last_r <= last_nxt;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign state = state_r;
endmodule : lic_debounce
`default_nettype wire

// file: verilog/lic_top.sv
// Logic input conditioning: contact debounce, virtual words, combination
`timescale 1ns/1ps
`default_nettype none
module lic_top
   import lic_pkg::*;
#(
   parameter int DEB_50_CYC = LIC_DEB_50_CYC, // Debounce cycles at 50 Hz
   parameter int DEB_60_CYC = LIC_DEB_60_CYC // Debounce cycles at 60 Hz
)
(
   input wire logic clk, // System clock, 20 MHz
   input wire logic rst_b, // Async reset, active low
   input wire logic freq_60, // Power frequency select, 1 = 60 Hz
   input wire logic [LIC_N_CONTACT-1:0] contact_raw, // Contact levels, 1 = closed
   input wire logic ser_wr, // Serial port word write strobe
   input wire logic [15:0] ser_addr, // Serial port word address
   input wire logic [LIC_WORD_W-1:0] ser_wdata, // Serial port write data
   input wire logic pnl_wr, // Front panel write strobe
   input wire logic [15:0] pnl_addr, // Front panel word address
   input wire logic [LIC_WORD_W-1:0] pnl_wdata, // Front panel write data
   input wire logic rd_en, // Word read strobe
   input wire logic [15:0] rd_addr, // Word read address
   output logic [LIC_WORD_W-1:0] rd_data, // Word read data, registered
   output logic rd_hit, // Read address was in range, registered
   input wire logic [LIC_N_LOGIC*LIC_SEL_W-1:0] sel_cfg, // Per-input selections
   output logic [LIC_N_CONTACT-1:0] contact_state, // Debounced, 1 = closed
   output logic [LIC_N_LOGIC-1:0] virt_state, // Virtual on, registered
   output logic [LIC_N_LOGIC-1:0] logic_state // Asserted logic inputs
);
   import lic_pkg::*;

   logic [LIC_WORD_W-1:0] vword_r [LIC_N_LOGIC];
   logic [LIC_WORD_W-1:0] vword_nxt [LIC_N_LOGIC];
   logic [LIC_N_LOGIC-1:0] logic_r, logic_nxt;
   logic [LIC_N_LOGIC-1:0] von_r, von_nxt;
   logic [LIC_WORD_W-1:0] rd_data_r, rd_data_nxt;
   logic rd_hit_r, rd_hit_nxt;
   logic [LIC_DEB_W-1:0] period_cyc;
   logic ser_hit;
   logic pnl_hit;
   logic rd_in_map;
   logic [4:0] ser_idx;
   logic [4:0] pnl_idx;
   logic [4:0] rd_idx;

   // ==========================================================
   // Contact debounce
   assign period_cyc = freq_60 ? LIC_DEB_W'(DEB_60_CYC) : LIC_DEB_W'(DEB_50_CYC);

   genvar gi;
   generate
      for (gi = 0; gi < LIC_N_CONTACT; gi++) begin : g_deb
         lic_debounce u_deb (
            .clk(clk),
            .rst_b(rst_b),
            .raw(contact_raw[gi]),
            .period_cyc(period_cyc),
            .state(contact_state[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Address decode helpers
   function automatic logic in_range(input logic [15:0] a);
      in_range = (a >= LIC_VIRT_ADDR_FIRST) && (a <= LIC_VIRT_ADDR_LAST)
                 && ((a - LIC_VIRT_ADDR_FIRST) < 16'(LIC_N_LOGIC));
   endfunction : in_range

   function automatic logic [4:0] idx_of(input logic [15:0] a);
      logic [15:0] d;
      d = a - LIC_VIRT_ADDR_FIRST;
      idx_of = d[4:0];
   endfunction : idx_of

   // ==========================================================
   // Address decode
   assign ser_hit = ser_wr && in_range(ser_addr);
   assign pnl_hit = pnl_wr && in_range(pnl_addr);
   assign rd_in_map = in_range(rd_addr);
   assign ser_idx = idx_of(ser_addr);
   assign pnl_idx = idx_of(pnl_addr);
   assign rd_idx = idx_of(rd_addr);

   // ==========================================================
   // Virtual input words
   always_comb begin
      for (int i = 0; i < LIC_N_LOGIC; i++) begin
         vword_nxt[i] = vword_r[i];
      end
      // Panel first so a simultaneous serial write to the same word wins
      if (pnl_hit) begin
         vword_nxt[pnl_idx] = pnl_wdata;
      end
      if (ser_hit) begin
         vword_nxt[ser_idx] = ser_wdata;
      end
      for (int i = 0; i < LIC_N_LOGIC; i++) begin
         von_nxt[i] = (vword_nxt[i] != LIC_WORD_OFF);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < LIC_N_LOGIC; i++) begin
            vword_r[i] <= LIC_WORD_RESET;
         end
         von_r <= '0;
      end else begin
         for (int i = 0; i < LIC_N_LOGIC; i++) begin
            vword_r[i] <= vword_nxt[i];
         end
         von_r <= von_nxt;
      end
   end

   // ==========================================================
   // Read back
   always_comb begin
      rd_data_nxt = rd_data_r;
      rd_hit_nxt = 1'b0;
      if (rd_en) begin
         if (rd_in_map) begin
            rd_data_nxt = vword_r[rd_idx];
            rd_hit_nxt = 1'b1;
         end else begin
            rd_data_nxt = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_r <= '0;
         rd_hit_r <= 1'b0;
      end else begin
         rd_data_r <= rd_data_nxt;
         rd_hit_r <= rd_hit_nxt;
      end
   end

   // ==========================================================
   // Combination logic
   function automatic logic combine(input logic [LIC_SEL_W-1:0] s, input logic c,
                                    input logic v);
      lic_sel_t sel;
      sel = lic_sel_t'(s);
      case (sel)
         LIC_SEL_DISABLED: combine = 1'b0;
         LIC_SEL_C_CLOSED: combine = c;
         LIC_SEL_C_OPEN: combine = !c;
         LIC_SEL_V_ON: combine = v;
         LIC_SEL_V_OFF: combine = !v;
         LIC_SEL_CLOSED_AND_VON: combine = c & v;
         LIC_SEL_CLOSED_AND_VOFF: combine = c & !v;
         LIC_SEL_OPEN_AND_VON: combine = !c & v;
         LIC_SEL_OPEN_AND_VOFF: combine = !c & !v;
         LIC_SEL_CLOSED_OR_VON: combine = c | v;
         LIC_SEL_CLOSED_OR_VOFF: combine = c | !v;
         LIC_SEL_OPEN_OR_VON: combine = !c | v;
         LIC_SEL_OPEN_OR_VOFF: combine = !c | !v;
         LIC_SEL_CLOSED_XOR_VON: combine = c ^ v;
         LIC_SEL_CLOSED_XOR_VOFF: combine = c ^ !v;
         LIC_SEL_OPEN_XOR_VON: combine = !c ^ v;
         LIC_SEL_OPEN_XOR_VOFF: combine = !c ^ !v;
         default: combine = 1'b0;
      endcase
   endfunction : combine

   // Inputs without a contact accept only never, virtual on and virtual off
   function automatic logic combine_v(input logic [LIC_SEL_W-1:0] s, input logic v);
      lic_sel_t sel;
      sel = lic_sel_t'(s);
      case (sel)
         LIC_SEL_V_ON: combine_v = v;
         LIC_SEL_V_OFF: combine_v = !v;
         default: combine_v = 1'b0;
      endcase
   endfunction : combine_v

   always_comb begin
      for (int i = 0; i < LIC_N_CONTACT; i++) begin
         logic_nxt[i] = combine(sel_cfg[i*LIC_SEL_W +: LIC_SEL_W], contact_state[i],
                                von_r[i]);
      end
      for (int i = LIC_N_CONTACT; i < LIC_N_LOGIC; i++) begin
         logic_nxt[i] = combine_v(sel_cfg[i*LIC_SEL_W +: LIC_SEL_W], von_r[i]);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         logic_r <= '0;
      end else begin
         logic_r <= logic_nxt;
      end
   end

   // ==========================================================
   // Outputs
   // Level outputs: functions stay invoked while asserted, any fan-out
   assign logic_state = logic_r;
   // No pulse stretching: a momentary dwell is the spacing of its two writes
   assign virt_state = von_r;
   assign rd_data = rd_data_r;
   assign rd_hit = rd_hit_r;
endmodule : lic_top
`default_nettype wire

// file: bench/lic_monitor.sv
// Checker of the logic input block ports
`timescale 1ns/1ps
`default_nettype none
module lic_monitor
   import lic_pkg::*;
#(
   parameter int DEB_MIN_CYC = LIC_DEB_60_CYC // Shortest debounce interval in cycles
)
(
   input wire logic clk, // Clock
   input wire logic rst_b, // Reset
   input wire logic [LIC_N_CONTACT-1:0] contact_raw, // Raw
   input wire logic ser_wr, // Strobe
   input wire logic [15:0] ser_addr, // Address
   input wire logic [LIC_WORD_W-1:0] ser_wdata, // Data
   input wire logic pnl_wr, // Strobe
   input wire logic [15:0] pnl_addr, // Address
   input wire logic rd_en, // Read
   input wire logic [15:0] rd_addr, // Address
   input wire logic [LIC_WORD_W-1:0] rd_data, // Data
   input wire logic rd_hit, // Hit
   input wire logic [LIC_N_LOGIC*LIC_SEL_W-1:0] sel_cfg, // Codes
   input wire logic [LIC_N_CONTACT-1:0] contact_state, // Debounced
   input wire logic [LIC_N_LOGIC-1:0] virt_state, // Virtual
   input wire logic [LIC_N_LOGIC-1:0] logic_state // Logic
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic raw_q_r;
   logic [19:0] run_r;
   // ==========================================
   // Cycles the raw level of contact 0 has been steady
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         raw_q_r <= 1'b0;
         run_r <= 20'h00000;
      end else begin
         raw_q_r <= contact_raw[0];
         run_r <= (contact_raw[0] != raw_q_r) ? 20'h00000 : run_r + 20'h00001;
      end
   end
   sequence s_w0_on;
      ser_wr && ser_addr == LIC_VIRT_ADDR_FIRST && ser_wdata != LIC_WORD_OFF;
   endsequence
   property p_w0_on;
      s_w0_on |=> virt_state[0];
   endproperty
   property p_hold0;
      !(ser_wr && ser_addr == LIC_VIRT_ADDR_FIRST)
         && !(pnl_wr && pnl_addr == LIC_VIRT_ADDR_FIRST) |=> $stable(virt_state[0]);
   endproperty
   property p_rd_hit;
      rd_en && rd_addr >= LIC_VIRT_ADDR_FIRST && rd_addr < LIC_VIRT_ADDR_LAST |=> rd_hit;
   endproperty
   property p_rd_miss;
      rd_en && rd_addr == LIC_VIRT_ADDR_LAST |=> !rd_hit && rd_data == LIC_WORD_OFF;
   endproperty
   property p_von;
      sel_cfg[4:0] == LIC_SEL_V_ON |=> logic_state[0] == $past(virt_state[0]);
   endproperty
   property p_xor;
      sel_cfg[4:0] == LIC_SEL_CLOSED_XOR_VON
         |=> logic_state[0] == ($past(contact_state[0]) ^ $past(virt_state[0]));
   endproperty
   property p_only_v;
      sel_cfg[99:95] == LIC_SEL_C_CLOSED |=> !logic_state[19];
   endproperty
   property p_deb;
      $rose(contact_state[0]) |-> run_r > 20'(DEB_MIN_CYC - 8);
   endproperty
   a_w0_on: assert property (p_w0_on)
      else $error("word 0 not on");
   a_hold0: assert property (p_hold0)
      else $error("word 0 moved");
   a_rd_hit: assert property (p_rd_hit)
      else $error("read hit missing");
   a_rd_miss: assert property (p_rd_miss)
      else $error("unmapped read hit");
   a_von: assert property (p_von)
      else $error("input 1 virtual wrong");
   a_xor: assert property (p_xor)
      else $error("input 1 xor wrong");
   a_only_v: assert property (p_only_v)
      else $error("input 20 used contact");
   a_deb: assert property (p_deb)
      else $error("contact accepted early");
endmodule : lic_monitor
bind lic_top lic_monitor #(.DEB_MIN_CYC(DEB_60_CYC)) i_mon (.clk(clk), .rst_b(rst_b),
   .contact_raw(contact_raw),
   .ser_wr(ser_wr), .ser_addr(ser_addr), .ser_wdata(ser_wdata), .pnl_wr(pnl_wr),
   .pnl_addr(pnl_addr), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
   .rd_hit(rd_hit), .sel_cfg(sel_cfg), .contact_state(contact_state),
   .virt_state(virt_state), .logic_state(logic_state));
`default_nettype wire

// file: bench/lic_field_model.sv
// Field contacts and serial master
`timescale 1ns/1ps
`default_nettype none
module lic_field_model
   import lic_pkg::*;
(
   input wire logic clk, // Clock
   output logic [LIC_N_CONTACT-1:0] contact_raw, // Levels
   output logic ser_wr, // Strobe
   output logic [15:0] ser_addr, // Address
   output logic [LIC_WORD_W-1:0] ser_wdata // Data
);
   initial begin
      contact_raw = '0;
      ser_wr = 1'b0;
      ser_addr = 16'h0000;
      ser_wdata = 16'h0000;
   end
   // Caller sets how long each level is held; the debounce test holds some for less than one power cycle
   task automatic set_contact(input int i, input logic lvl);
      @(negedge clk);
      contact_raw[i] = lvl;
   endtask : set_contact
   // One word write; released lines show the inverse value
   task automatic ser_write(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      ser_wr = 1'b1;
      ser_addr = a;
      ser_wdata = d;
      @(negedge clk);
      ser_wr = 1'b0;
      ser_addr = ~a;
      ser_wdata = ~d;
   endtask : ser_write
endmodule : lic_field_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench of the logic input block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import lic_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic pnl_wr = 1'b0;
   logic [15:0] pnl_addr = 16'h0000;
   logic [15:0] pnl_wdata = 16'h0000;
   logic rd_en = 1'b0;
   logic [15:0] rd_addr = 16'h0000;
   logic [99:0] sel_cfg = '0;
   logic freq_60 = 1'b1;
   // Shortened debounce intervals keep the run to a few thousand cycles
   localparam int TB_DEB_60 = 334;
   localparam int TB_DEB_50 = 400;
   localparam int TB_LIMIT_CYC = 10000;
   logic [13:0] contact_raw, contact_state;
   logic ser_wr, rd_hit;
   logic [15:0] ser_addr, ser_wdata, rd_data;
   logic [19:0] virt_state, logic_state;
   int miscompares = 0;
   int comparisons = 0;
   always #25 clk = ~clk;
   lic_field_model i_far (.clk(clk), .contact_raw(contact_raw), .ser_wr(ser_wr),
      .ser_addr(ser_addr), .ser_wdata(ser_wdata));
   lic_top #(.DEB_50_CYC(TB_DEB_50), .DEB_60_CYC(TB_DEB_60)) i_dut (.clk(clk), .rst_b(rst_b),
      .freq_60(freq_60), .contact_raw(contact_raw),
      .ser_wr(ser_wr), .ser_addr(ser_addr), .ser_wdata(ser_wdata), .pnl_wr(pnl_wr),
      .pnl_addr(pnl_addr), .pnl_wdata(pnl_wdata), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_hit(rd_hit), .sel_cfg(sel_cfg), .contact_state(contact_state),
      .virt_state(virt_state), .logic_state(logic_state));
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic print_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   task automatic pnl_write(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      pnl_wr = 1'b1;
      pnl_addr = a;
      pnl_wdata = d;
      @(negedge clk);
      pnl_wr = 1'b0;
      pnl_addr = ~a;
      pnl_wdata = ~d;
   endtask : pnl_write
   task automatic rd_word(input logic [15:0] a, input logic [15:0] d, input logic h);
      @(negedge clk);
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge clk);
      rd_en = 1'b0;
      chk("rd_data", d, rd_data);
      chk("rd_hit", h, rd_hit);
   endtask : rd_word
   function automatic logic exp_l(input int k, input logic c, input logic v, input logic hc);
      logic cp, vp;
      cp = ((k - 5) % 4 < 2) ? c : !c;
      vp = ((k - 5) % 2 == 0) ? v : !v;
      if (k == 0) return 1'b0;
      if (k == 3) return v;
      if (k == 4) return !v;
      if (!hc || k > 16) return 1'b0;
      if (k < 3) return (k == 1) ? c : !c;
      if (k < 9) return cp & vp;
      if (k < 13) return cp | vp;
      return cp ^ vp;
   endfunction : exp_l
   task automatic t_words;
      logic [15:0] a;
      for (int i = 0; i < LIC_N_LOGIC; i++) begin
         a = LIC_VIRT_ADDR_FIRST + 16'(i);
         if (i % 2 == 0) begin
            i_far.ser_write(a, 16'h0001 << (i % 16));
         end else begin
            pnl_write(a, 16'h8000 >> (i % 16));
         end
         chk("virt_on", 1, virt_state[i]);
      end
      rd_word(16'h0093, 16'h1000, 1'b1);
      i_far.ser_write(LIC_VIRT_ADDR_LAST, 16'h0001);
      repeat (100) @(negedge clk);
      chk("virt_held", 20'hfffff, virt_state);
      rd_word(LIC_VIRT_ADDR_LAST, 16'h0000, 1'b0);
      for (int i = 0; i < LIC_N_LOGIC; i++) begin
         i_far.ser_write(LIC_VIRT_ADDR_FIRST + 16'(i), 16'h0000);
         chk("virt_off", 0, virt_state[i]);
      end
      $display("test words done");
   endtask : t_words
   task automatic t_sel(input logic c);
      for (int v = 0; v < 2; v++) begin
         i_far.ser_write(LIC_VIRT_ADDR_FIRST, 16'(v * 8));
         i_far.ser_write(16'h00a3, 16'(v * 165));
         for (int k = 0; k < 18; k++) begin
            @(negedge clk);
            sel_cfg[4:0] = 5'(k);
            sel_cfg[99:95] = 5'(k);
            repeat (2) @(negedge clk);
            chk("logic1", exp_l(k, c, v[0], 1'b1), logic_state[0]);
            chk("logic20", exp_l(k, c, v[0], 1'b0), logic_state[19]);
            chk("logic_rest", 0, logic_state[18:1]);
         end
      end
      $display("test selections done");
   endtask : t_sel
   task automatic t_debounce(input logic f60, input int n, input int ch);
      @(negedge clk);
      freq_60 = f60;
      i_far.set_contact(ch, 1'b1);
      repeat (n - 4) @(negedge clk);
      chk("early", 0, contact_state[ch]);
      i_far.set_contact(ch, 1'b0);
      repeat (n + 8) @(negedge clk);
      chk("short_pulse", 0, contact_state[ch]);
      i_far.set_contact(ch, 1'b1);
      repeat (n - 4) @(negedge clk);
      i_far.set_contact(ch, 1'b0);
      i_far.set_contact(ch, 1'b1);
      repeat (n - 4) @(negedge clk);
      chk("held", 0, contact_state[ch]);
      repeat (8) @(negedge clk);
      chk("accepted", 1, contact_state[ch]);
      $display("test debounce done");
   endtask : t_debounce
   initial begin
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      chk("reset_virt", 0, virt_state);
      chk("reset_logic", 0, logic_state);
      chk("reset_contact", 0, contact_state);
      chk("reset_rd", 0, {rd_hit, rd_data});
      t_words();
      t_sel(1'b0);
      t_debounce(1'b1, TB_DEB_60, 0);
      t_debounce(1'b0, TB_DEB_50, 13);
      chk("contacts", 14'h2001, contact_state);
      t_sel(1'b1);
      print_verdict();
   end
   initial begin
      // Limit well beyond the few thousand cycles the tests take
      repeat (TB_LIMIT_CYC) @(posedge clk);
      miscompares++;
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
